// [net_live_defs.svh]
// Offsets, field positions, reset values and timing constants
`ifndef NET_LIVE_DEFS_SVH
`define NET_LIVE_DEFS_SVH

// Clock and time base
`define CLK_HZ 40000000
`define MS_HZ 1000
`define TICK_CYCLES (`CLK_HZ / `MS_HZ)

// Heartbeat send periods in ms
`define HB_MS_FAST 14'h03c
`define HB_MS_250 14'h078
`define HB_MS_125 14'h0f0
`define HB_MS_50 14'h258
`define HB_MS_20 14'h5dc
`define HB_MS_10 14'hbb8

// Missing-peer timeouts in ms
`define TO_MS_FAST 14'h0b4
`define TO_MS_250 14'h168
`define TO_MS_125 14'h2d0
`define TO_MS_50 14'h708
`define TO_MS_20 14'h1194
`define TO_MS_10 14'h2328

// Start-up hold-off and indicator blink half period in ms
`define STARTUP_MS 14'h1388
`define BLINK_MS 14'h1f4

// Register offsets
`define ADDR_CTRL 8'h00
`define ADDR_CFG 8'h04
`define ADDR_STAT 8'h08
`define ADDR_ZERO 8'h0c

// Control register fields
`define CTRL_NUM_LSB 0
`define CTRL_BAUD_LSB 4
`define CTRL_PROG 7
`define CTRL_RRUN 8
`define CTRL_RIO 9
`define CTRL_SCREEN 10
`define CTRL_RUN 11
`define CTRL_RST 12'h000

// Config register fields
`define CFG_PLESS_LSB 8
`define CFG_RST 16'h0000

`endif

// [net_live_pkg.sv]
// Types and timing decode shared by the liveness monitor
`default_nettype none
`include "net_live_defs.svh"
package net_live_pkg;

    typedef enum logic [2:0] {
        BAUD_1000, BAUD_500, BAUD_250, BAUD_125,
        BAUD_50, BAUD_20, BAUD_10, BAUD_RSVD
    } baud_e;

    typedef enum logic {RUN_STOP, RUN_GO} run_e;

    typedef logic [13:0] ms_t;

    function automatic ms_t period_ms(baud_e b);
        case (b)
            BAUD_1000, BAUD_500: period_ms = `HB_MS_FAST;
            BAUD_250: period_ms = `HB_MS_250;
            BAUD_125: period_ms = `HB_MS_125;
            BAUD_50: period_ms = `HB_MS_50;
            BAUD_20: period_ms = `HB_MS_20;
            default: period_ms = `HB_MS_10;
        endcase
    endfunction : period_ms

    function automatic ms_t timeout_ms(baud_e b);
        case (b)
            BAUD_1000, BAUD_500: timeout_ms = `TO_MS_FAST;
            BAUD_250: timeout_ms = `TO_MS_250;
            BAUD_125: timeout_ms = `TO_MS_125;
            BAUD_50: timeout_ms = `TO_MS_50;
            BAUD_20: timeout_ms = `TO_MS_20;
            default: timeout_ms = `TO_MS_10;
        endcase
    endfunction : timeout_ms

endpackage : net_live_pkg
`default_nettype wire

// [watch_if.sv]
// Link between the monitor core and the per-station timers
`timescale 1ns/1ps
`default_nettype none
interface watch_if;
    logic ms_tick;
    logic [7:0] hb_hit;
    net_live_pkg::ms_t to_ms;
    logic [7:0] absent;

    modport timer (input ms_tick, input hb_hit, input to_ms, output absent);
    modport core (output ms_tick, output hb_hit, output to_ms, input absent);
endinterface : watch_if
`default_nettype wire

// [peer_timer.sv]
// Per-station heartbeat timeout counters
`timescale 1ns/1ps
`default_nettype none
module peer_timer (
    input wire logic clock,
    input wire logic sys_rst,
    watch_if.timer w
);
    logic [7:0] absent_ff;

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_stn
            net_live_pkg::ms_t cnt_ff;
            net_live_pkg::ms_t nxt_cnt;
            wire expired = (nxt_cnt >= w.to_ms);
            assign nxt_cnt = w.hb_hit[i] ? '0 :
                (w.ms_tick && cnt_ff < w.to_ms) ?
                net_live_pkg::ms_t'(cnt_ff + 14'h0001) : cnt_ff;
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    cnt_ff <= '0;
                    absent_ff[i] <= 1'b0;
                end else begin
                    cnt_ff <= nxt_cnt;
                    absent_ff[i] <= expired && !w.hb_hit[i];
                end
            end
        end
    endgenerate

    assign w.absent = absent_ff;

    hb_clears_a: assert property (@(posedge clock) disable iff (sys_rst)
        |w.hb_hit |=> ((absent_ff & $past(w.hb_hit)) == 8'h00))
        else $error("absence bit not cleared by heartbeat");

endmodule : peer_timer
`default_nettype wire

// [net_live_monitor.sv]
// Station liveness monitor: heartbeats, absence bits, indicator, fallbacks
// Operation
// - Indicator dark if network down, steady on fault, blinking if healthy.
// - Initialised network with an undetected peer shows steady indicator.
// - Heartbeat every 60/60/120/240/600/1500/3000 ms per baud rate.
// - Peer missing after 180/180/360/720/1800/4500/9000 ms of silence.
// - Eight absence bits, one per station, set when its heartbeat timeout expires.
// - A detected missing peer turns the indicator steady on.
// - A program station zeroes inputs from a lost program-less peer.
// - Program-less remote I/O station zeroes station 1 outputs on loss.
// - A station with no station number sends no heartbeat and keeps a dark indicator.
// - During network reconfiguration the station goes to stopped state.
// - Master-follow keeps running on old data until station 1 times out.
// - Then master-follow zeroes received data and keeps its state.
// - With remote I/O too it also stops, only while status screen shown.
// - Such a remote I/O station runs again when station 1 goes running.
// - Data from a station is usable only while its absence bit is clear.
// - absent_eval_ok rises about 5 s after power-up; absence bits are not held off by it.
`timescale 1ns/1ps
`default_nettype none
`include "net_live_defs.svh"
module net_live_monitor #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic hb_rx_valid,
    input wire logic [2:0] hb_rx_station,
    input wire logic net_init_done,
    input wire logic config_fault,
    input wire logic own_fault,
    input wire logic reconfig_active,
    input wire logic master_mode_valid,
    input wire logic master_mode_run,
    output logic hb_tx,
    output logic led_net,
    output logic [7:0] station_absent_bits,
    output logic run_state,
    output logic [7:0] rx_zero,
    output logic [7:0] rx_use_ok,
    output logic absent_eval_ok
);
    // Software registers
    logic [11:0] ctrl_ff;
    logic [15:0] cfg_ff;
    logic [31:0] rdata_ff;

    // Time base and timers
    logic [31:0] div_ff;
    logic tick_ff;
    net_live_pkg::ms_t tx_cnt_ff;
    net_live_pkg::ms_t boot_cnt_ff;
    net_live_pkg::ms_t blink_cnt_ff;
    logic blink_ff;
    logic boot_done_ff;

    // Output flops
    logic hb_tx_ff;
    logic led_ff;
    logic [7:0] absent_ff;
    net_live_pkg::run_e run_ff;
    logic [7:0] zero_ff;
    logic [7:0] use_ok_ff;

    watch_if w ();

    // Control field decode
    wire [3:0] station_number = ctrl_ff[`CTRL_NUM_LSB +: 4];
    wire net_live_pkg::baud_e baud =
        net_live_pkg::baud_e'(ctrl_ff[`CTRL_BAUD_LSB +: 3]);
    wire has_program = ctrl_ff[`CTRL_PROG];
    wire remote_run = ctrl_ff[`CTRL_RRUN];
    wire remote_io = ctrl_ff[`CTRL_RIO];
    wire status_screen = ctrl_ff[`CTRL_SCREEN];
    wire local_run = ctrl_ff[`CTRL_RUN];
    wire [7:0] configured = cfg_ff[7:0];
    wire [7:0] program_less = cfg_ff[`CFG_PLESS_LSB +: 8];

    // Numbers 1..8 are valid; 0 means unassigned
    wire joined = (station_number != 4'h0) && (station_number <= 4'h8);
    wire [2:0] own_idx = 3'(station_number - 4'h1);
    wire [7:0] own_bit = joined ? (8'h01 << own_idx) : 8'h00;
    wire [7:0] peers = configured & ~own_bit;
    wire [7:0] missing = w.absent & peers & {8{joined}};
    wire master_lost = missing[0] && own_idx != 3'h0;
    wire net_up = joined && net_init_done && !config_fault;

    // Register access decode
    wire wr_ctrl = reg_wr && reg_addr == `ADDR_CTRL;
    wire wr_cfg = reg_wr && reg_addr == `ADDR_CFG;
    wire [31:0] stat_word = {20'h00000, boot_done_ff, run_ff, led_ff,
        hb_tx_ff, absent_ff};
    wire [31:0] rd_mux =
        reg_addr == `ADDR_CTRL ? {20'h00000, ctrl_ff} :
        reg_addr == `ADDR_CFG ? {16'h0000, cfg_ff} :
        reg_addr == `ADDR_STAT ? stat_word :
        reg_addr == `ADDR_ZERO ? {16'h0000, use_ok_ff, zero_ff} :
        32'h00000000;

    // Millisecond divider
    wire tick_wrap = div_ff == 32'(TICK_CYCLES - 1);
    wire [31:0] nxt_div = tick_wrap ? 32'h00000000 : div_ff + 32'h00000001;

    // Heartbeat transmit timer
    wire net_live_pkg::ms_t period = net_live_pkg::period_ms(baud);
    wire tx_due = tick_ff && (tx_cnt_ff >= period - 14'h0001);
    wire net_live_pkg::ms_t nxt_tx_cnt = !joined ? '0 :
        tx_due ? '0 :
        tick_ff ? net_live_pkg::ms_t'(tx_cnt_ff + 14'h0001) : tx_cnt_ff;

    // Start-up hold-off and blink
    wire boot_end = tick_ff && boot_cnt_ff == `STARTUP_MS - 14'h0001;
    wire blink_end = tick_ff && blink_cnt_ff == `BLINK_MS - 14'h0001;
    wire net_live_pkg::ms_t nxt_boot_cnt = boot_done_ff ? boot_cnt_ff :
        tick_ff ? net_live_pkg::ms_t'(boot_cnt_ff + 14'h0001) : boot_cnt_ff;
    wire net_live_pkg::ms_t nxt_blink_cnt = blink_end ? '0 :
        tick_ff ? net_live_pkg::ms_t'(blink_cnt_ff + 14'h0001) : blink_cnt_ff;

    // Indicator: dark, steady or blinking
    wire fault_seen = own_fault || |missing;
    wire nxt_led = !net_up ? 1'b0 :
        fault_seen ? 1'b1 :
        blink_ff;

    // Received-data zeroing per sending station
    wire [7:0] zero_prog = has_program ? (missing & program_less) : 8'h00;
    wire zero_rio = !has_program && remote_io && missing[0];
    wire zero_all = remote_run && master_lost;
    wire [7:0] nxt_zero = zero_prog |
        {7'h00, zero_rio} |
        {8{zero_all}};
    wire [7:0] nxt_use_ok = peers & ~missing & ~nxt_zero;

    // Operating state
    wire rio_stop = remote_run && remote_io && status_screen && master_lost;
    wire master_ev = remote_run && master_mode_valid;
    wire net_live_pkg::run_e nxt_run =
        reconfig_active ? net_live_pkg::RUN_STOP :
        rio_stop ? net_live_pkg::RUN_STOP :
        master_ev ? (master_mode_run ? net_live_pkg::RUN_GO :
            net_live_pkg::RUN_STOP) :
        remote_run ? run_ff :
        (local_run ? net_live_pkg::RUN_GO : net_live_pkg::RUN_STOP);

    // Timer links
    assign w.ms_tick = tick_ff;
    assign w.to_ms = net_live_pkg::timeout_ms(baud);
    assign w.hb_hit = (hb_rx_valid && joined) ?
        (8'h01 << hb_rx_station) & ~own_bit : 8'h00;

    peer_timer u_timer (
        .clock(clock),
        .sys_rst(sys_rst),
        .w(w.timer)
    );

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_ff <= `CTRL_RST;
            cfg_ff <= `CFG_RST;
            rdata_ff <= 32'h00000000;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= reg_wdata[11:0];
            end
            if (wr_cfg) begin
                cfg_ff <= reg_wdata[15:0];
            end
            rdata_ff <= reg_rd ? rd_mux : 32'h00000000;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            div_ff <= 32'h00000000;
            tick_ff <= 1'b0;
            tx_cnt_ff <= '0;
            boot_cnt_ff <= '0;
            boot_done_ff <= 1'b0;
            blink_cnt_ff <= '0;
            blink_ff <= 1'b0;
        end else begin
            div_ff <= nxt_div;
            tick_ff <= tick_wrap;
            tx_cnt_ff <= nxt_tx_cnt;
            boot_cnt_ff <= nxt_boot_cnt;
            boot_done_ff <= boot_done_ff || boot_end;
            blink_cnt_ff <= nxt_blink_cnt;
            blink_ff <= blink_ff ^ blink_end;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            hb_tx_ff <= 1'b0;
            led_ff <= 1'b0;
            absent_ff <= 8'h00;
            run_ff <= net_live_pkg::RUN_STOP;
            zero_ff <= 8'h00;
            use_ok_ff <= 8'h00;
        end else begin
            hb_tx_ff <= tx_due && joined;
            led_ff <= nxt_led;
            absent_ff <= missing;
            run_ff <= nxt_run;
            zero_ff <= nxt_zero;
            use_ok_ff <= nxt_use_ok;
        end
    end

    assign reg_rdata = rdata_ff;
    assign hb_tx = hb_tx_ff;
    assign led_net = led_ff;
    assign station_absent_bits = absent_ff;
    assign run_state = run_ff == net_live_pkg::RUN_GO;
    assign rx_zero = zero_ff;
    assign rx_use_ok = use_ok_ff;
    assign absent_eval_ok = boot_done_ff;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_master_gone;
        remote_run && remote_io && status_screen && master_lost;
    endsequence

    sequence s_master_runs;
        master_mode_valid && master_mode_run && remote_run;
    endsequence

    unjoined_dark_a: assert property (!joined |=> !led_net)
        else $error("indicator lit without a station number");

    net_down_dark_a: assert property (
        (!net_init_done || config_fault) |=> !led_net)
        else $error("indicator lit while network down");

    fault_steady_a: assert property (
        (net_up && |missing) [*2] |=> led_net)
        else $error("indicator not steady on a missing peer");

    absent_bit_a: assert property (
        (joined && |(w.absent & peers)) |=> |station_absent_bits)
        else $error("absence bit not raised");

    tx_gap_a: assert property (
        hb_tx |=> !hb_tx [*8])
        else $error("heartbeats too close together");

    reconfig_stop_a: assert property (
        reconfig_active |=> !run_state)
        else $error("running during reconfiguration");

    rio_stop_a: assert property (
        s_master_gone and !master_mode_valid |=> !run_state)
        else $error("remote station did not stop");

    follow_run_a: assert property (
        s_master_runs and !reconfig_active and !master_lost |=> run_state)
        else $error("remote station did not follow master run");

    keep_state_a: assert property (
        (zero_all && !remote_io && !master_mode_valid && !reconfig_active)
        |=> run_state == $past(run_state) && rx_zero == 8'hff)
        else $error("master loss changed state or kept data");

    zero_peer_a: assert property (
        (has_program && |(missing & program_less))
        |=> (rx_zero & $past(missing & program_less)) != 8'h00)
        else $error("lost peer data not zeroed");

    boot_hold_a: assert property (
        !boot_done_ff |=> !absent_eval_ok || $past(boot_end))
        else $error("absence evaluation released early");

endmodule : net_live_monitor
`default_nettype wire

// [peer_model.sv]
// Far-side peer stations sending periodic heartbeats
`timescale 1ns/1ps
`default_nettype none
module peer_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] alive,
    input wire logic [15:0] per,
    output logic hb_rx_valid,
    output logic [2:0] hb_rx_station
);
    logic [15:0] cnt_ff;
    logic [3:0] idx_ff;

    // One sweep over the live stations every per+9 cycles
    always_ff @(posedge clock) begin
        hb_rx_valid <= 1'b0;
        hb_rx_station <= ~hb_rx_station;
        if (sys_rst) begin
            cnt_ff <= 16'h0000;
            idx_ff <= 4'h8;
            hb_rx_station <= 3'h0;
        end else if (idx_ff < 4'h8) begin
            if (alive[idx_ff[2:0]]) begin
                hb_rx_valid <= 1'b1;
                hb_rx_station <= idx_ff[2:0];
            end
            idx_ff <= idx_ff + 4'h1;
        end else if (cnt_ff >= per) begin
            cnt_ff <= 16'h0000;
            idx_ff <= 4'h0;
        end else begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end
endmodule : peer_model
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the station liveness monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int TK = 4;
    typedef struct {int bd; int pm; int tm;} row_s;
    row_s rows[4] = '{'{0, 60, 180}, '{2, 120, 360}, '{4, 600, 1800},
        '{5, 1500, 4500}};
    logic clock, sys_rst, reg_wr, reg_rd, net_init_done, config_fault;
    logic own_fault, reconfig_active, master_mode_valid, master_mode_run;
    logic hb_rx_valid, hb_tx, led_net, run_state, absent_eval_ok;
    logic [2:0] hb_rx_station;
    logic [7:0] reg_addr, alive, station_absent_bits, rx_zero, rx_use_ok;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [15:0] per;
    int n_fail, checked, c, cyc, last_hb;

    net_live_monitor #(.TICK_CYCLES(TK)) dut (.clock, .sys_rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .hb_rx_valid,
        .hb_rx_station, .net_init_done, .config_fault, .own_fault,
        .reconfig_active, .master_mode_valid, .master_mode_run, .hb_tx,
        .led_net, .station_absent_bits, .run_state, .rx_zero, .rx_use_ok,
        .absent_eval_ok);
    peer_model peer (.clock, .sys_rst, .alive, .per, .hb_rx_valid,
        .hb_rx_station);

    task automatic print_verdict();
        $display("checks %0d fails %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk

    task automatic chkr(string n, int lo, int hi, int g);
        checked++;
        if (g < lo || g > hi) begin
            n_fail++;
            $display("[ERR] %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask : chkr

    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(logic [7:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic pa(logic [7:0] m, logic [15:0] p);
        @(posedge clock);
        alive <= m;
        per <= p;
    endtask : pa

    task automatic mpulse();
        @(posedge clock);
        master_mode_valid <= 1'b1;
        master_mode_run <= 1'b1;
        @(posedge clock);
        master_mode_valid <= 1'b0;
    endtask : mpulse

    task automatic cyc_n(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc_n

    task automatic hb_gap();
        c = 0;
        do begin
            @(posedge clock);
            c++;
        end while (hb_tx !== 1'b1 && c < 20000);
    endtask : hb_gap

    task automatic led_gap();
        logic v;
        v = led_net;
        c = 0;
        do begin
            @(posedge clock);
            c++;
        end while (led_net === v && c < 5000);
    endtask : led_gap

    task automatic wait_abs(int i, logic v);
        c = 0;
        do begin
            @(posedge clock);
            c++;
        end while (station_absent_bits[i] !== v && c < 40000);
        if (c >= 40000) n_fail++;
        #1;
    endtask : wait_abs

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (hb_rx_valid === 1'b1) last_hb <= cyc;
    end

    initial begin
        repeat (90000) @(posedge clock);
        n_fail++;
        print_verdict();
    end

    initial begin
        {sys_rst, reg_wr, reg_rd, net_init_done, config_fault} = 5'h10;
        {own_fault, reconfig_active, master_mode_valid} = 3'h0;
        master_mode_run = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        alive = 8'h00;
        per = 16'h00e0;
        {n_fail, checked, cyc, last_hb} = 128'h0;
        repeat (2) @(posedge clock);
        #1;
        chk("outs_rst", 32'h0, 32'({hb_tx, led_net, station_absent_bits,
            run_state, rx_zero, rx_use_ok, absent_eval_ok}));
        @(posedge clock);
        sys_rst <= 1'b0;
        net_init_done <= 1'b1;
        wr(8'h08, 32'hffff_ffff);
        wr(8'h10, 32'hffff_ffff);
        for (int a = 0; a < 20; a += 4) begin
            rd(8'(a));
            chk("reg_rst", 32'h0, d);
        end
        wr(8'h04, 32'h02);
        pa(8'h02, 16'h00e0);
        cyc_n(500);
        chk("led_unjoined", 32'h0, 32'(led_net));
        chk("eval_early", 32'h0, 32'(absent_eval_ok));
        $display("done: reset");
        foreach (rows[i]) begin
            wr(8'h00, 32'h81 | (rows[i].bd << 4));
            wr(8'h04, 32'h0202);
            rd(8'h00);
            chk("ctrl_rw", 32'h81 | (rows[i].bd << 4), d);
            pa(8'h02, 16'(rows[i].pm * TK - 16));
            hb_gap();
            hb_gap();
            chk("hb_period", rows[i].pm * TK, c);
            chk("abs_clear", 32'h0, 32'(station_absent_bits));
            pa(8'h00, per);
            wait_abs(1, 1'b1);
            chkr("timeout", rows[i].tm * TK - 4, rows[i].tm * TK + 8,
                cyc - last_hb);
            chk("abs_set", 32'h02, 32'(station_absent_bits));
            chk("zero_pless", 32'h02, 32'(rx_zero));
            chk("led_missing", 32'h1, 32'(led_net));
            $display("done: baud row %0d", i);
        end
        chk("eval_late", 32'h1, 32'(absent_eval_ok));
        wr(8'h00, 32'h01);
        pa(8'h02, 16'h00e0);
        wait_abs(1, 1'b0);
        led_gap();
        led_gap();
        chk("blink_half", 32'd2000, c);
        chk("use_ok", 32'h1, 32'(rx_use_ok[1]));
        @(posedge clock);
        config_fault <= 1'b1;
        cyc_n(3);
        chk("led_cfg", 32'h0, 32'(led_net));
        @(posedge clock);
        config_fault <= 1'b0;
        own_fault <= 1'b1;
        cyc_n(3);
        chk("led_fault", 32'h1, 32'(led_net));
        cyc_n(2100);
        chk("led_fault", 32'h1, 32'(led_net));
        @(posedge clock);
        own_fault <= 1'b0;
        wr(8'h04, 32'h06);
        wait_abs(2, 1'b1);
        cyc_n(3);
        chk("led_undet", 32'h1, 32'(led_net));
        chk("use_gone", 32'h0, 32'(rx_use_ok[2]));
        $display("done: indicator");
        wr(8'h04, 32'h01);
        wr(8'h00, 32'hf02);
        pa(8'h01, 16'h00e0);
        wait_abs(0, 1'b0);
        mpulse();
        cyc_n(3);
        chk("run_follow", 32'h1, 32'(run_state));
        pa(8'h00, per);
        cyc_n(400);
        chk("run_hold", 32'h1, 32'(run_state));
        chk("data_kept", 32'h0, 32'(rx_zero));
        wait_abs(0, 1'b1);
        cyc_n(3);
        chk("run_stop", 32'h0, 32'(run_state));
        chk("data_zero", 32'hff, 32'(rx_zero));
        pa(8'h01, per);
        wait_abs(0, 1'b0);
        mpulse();
        cyc_n(3);
        chk("run_again", 32'h1, 32'(run_state));
        wr(8'h00, 32'h902);
        pa(8'h00, per);
        wait_abs(0, 1'b1);
        cyc_n(3);
        chk("run_keep", 32'h1, 32'(run_state));
        chk("data_zero", 32'hff, 32'(rx_zero));
        @(posedge clock);
        reconfig_active <= 1'b1;
        cyc_n(3);
        chk("run_reconf", 32'h0, 32'(run_state));
        $display("done: master follow");
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
